// >>> dv/host_spi_master.sv
// Host serial master model that drives the modem link in mode 0
`timescale 1ns/10ps
module host_spi_master (
  output logic      serial_clock_in,
  output logic      select_in_b,
  output logic      mosi_in,
  input  wire logic miso_out,
  input  wire logic miso_oe
);
  // 6.25 MHz link clock, under the 8 MHz ceiling
  localparam int HALF = 80;
  int nfr;
  initial begin
    serial_clock_in = 1'b0;
    select_in_b = 1'b1;
    mosi_in = 1'b0;
    nfr = 0;
  end
  // Sends nb bytes from the top of tx; MISO bits shift in at the bottom of rx
  task automatic xfer(input logic [39:0] tx, input int nb, output logic [39:0] rx);
    logic [39:0] sr;
    sr = tx;
    rx = '0;
    select_in_b = 1'b0;
    nfr = nfr + 1;
    #(HALF + 3 * (nfr % 7));
    // Bytes follow back to back, as the double-buffered host allows
    for (int i = 0; i < nb * 8; i++) begin
      mosi_in = sr[39];
      sr = sr << 1;
      #(HALF);
      serial_clock_in = 1'b1;
      rx = {rx[38:0], miso_oe ? miso_out : 1'b1};
      #(HALF);
      serial_clock_in = 1'b0;
    end
    #(HALF);
    select_in_b = 1'b1;
    // A released line must not keep showing the last bit
    mosi_in = ~mosi_in;
  endtask : xfer
  // Clock and data activity with select high, which the modem must ignore
  task automatic noise(input int n);
    repeat (n) begin
      mosi_in = ~mosi_in;
      #(HALF) serial_clock_in = 1'b1;
      #(HALF) serial_clock_in = 1'b0;
    end
  endtask : noise
endmodule : host_spi_master

// >>> dv/tb_top.sv
// Testbench for the modem link: frames, control pins, status pins, word buffer
`timescale 1ns/10ps
module tb_top
  import modem_link_pkg::*;
;
  logic        clk_sys, rst_b, serial_clock_in, select_in_b, mosi_in, miso_out;
  logic        miso_oe, wake_request_in, radio_op_enable_in, modem_irq_b;
  logic        crc_ok_indicator, out_of_idle_indicator, core_irq_event;
  logic        crc_valid_in, word_valid, word_ready, oe_bad, oe_seen;
  logic [15:0] read_word_in;
  logic [23:0] word_data;
  logic [2:0]  radio_state;
  logic [39:0] rx;
  int          errors, n_tests;

  modem_link modem_link_i (.clk_sys, .rst_b, .serial_clock_in, .select_in_b, .mosi_in,
    .miso_out, .miso_oe, .wake_request_in, .radio_op_enable_in, .modem_irq_b,
    .crc_ok_indicator, .out_of_idle_indicator, .core_irq_event, .crc_valid_in,
    .read_word_in, .word_valid, .word_ready, .word_data, .radio_state);
  host_spi_master host_spi_master_i (.serial_clock_in, .select_in_b, .mosi_in,
    .miso_out, .miso_oe);

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge serial_clock_in) begin
    if (select_in_b && miso_oe) oe_bad = 1'b1;
    if (!select_in_b && miso_oe) oe_seen = 1'b1;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : tick
  task automatic xfer(input logic [39:0] tx, input int nb);
    host_spi_master_i.xfer(tx, nb, rx);
    tick(10);
  endtask : xfer
  task automatic ctrl(input logic [7:0] b);
    xfer({8'h01, 8'h00, b, 16'h0}, 3);
  endtask : ctrl
  task automatic pop(input logic [23:0] exp);
    for (int i = 0; i < 20 && word_valid !== 1'b1; i++) tick(1);
    chk("word_valid", 24'h1, 24'(word_valid));
    chk("word_data", exp, word_data);
    word_ready = 1'b1;
    tick(1);
    word_ready = 1'b0;
    tick(1);
  endtask : pop

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    chk("state", 24'(ST_IDLE), 24'(radio_state));
    chk("irq_b", 24'h1, 24'(modem_irq_b));
    chk("ind", 24'h0, 24'({crc_ok_indicator, out_of_idle_indicator}));
  endtask : t_reset
  task automatic t_frames;
    host_spi_master_i.noise(16);
    tick(10);
    chk("noise", 24'h0, 24'(word_valid));
    xfer({8'h05, 8'h12, 24'h0}, 2);
    chk("short", 24'h0, 24'(word_valid));
  endtask : t_frames
  task automatic t_buffer;
    logic [15:0] w [4] = '{16'ha001, 16'hb002, 16'hc003, 16'hd004};
    // Consumer stalls while four words arrive; the fourth has no room
    foreach (w[k]) xfer({8'h05, w[k], 16'h0}, 3);
    chk("ovf_irq_b", 24'h0, 24'(modem_irq_b));
    xfer({8'h82, 32'h0}, 3);
    chk("status", 24'h3800, 24'(rx[15:0]));
    chk("irq_off", 24'h1, 24'(modem_irq_b));
    for (int k = 0; k < 3; k++) pop({8'h05, w[k]});
    chk("drained", 24'h0, 24'(word_valid));
  endtask : t_buffer
  task automatic t_read;
    read_word_in = 16'h5ac3;
    oe_seen = 1'b0;
    tick(4);
    xfer({8'h87, 32'h0}, 3);
    chk("read", 24'h5ac3, 24'(rx[15:0]));
    chk("driven", 24'h1, 24'(oe_seen));
  endtask : t_read
  task automatic t_irq;
    core_irq_event = 1'b1;
    tick(1);
    core_irq_event = 1'b0;
    tick(3);
    chk("ev_irq_b", 24'h0, 24'(modem_irq_b));
    xfer({8'h82, 32'h0}, 3);
    chk("pend", 24'h1, 24'(rx[12]));
    chk("ev_off", 24'h1, 24'(modem_irq_b));
  endtask : t_irq
  task automatic t_modes;
    pwr_state_e st [3] = '{ST_RX, ST_TX, ST_CCA};
    for (int k = 0; k < 3; k++) begin
      ctrl(8'h81 + 8'(k));
      radio_op_enable_in = 1'b1;
      tick(6);
      chk("op", 24'(st[k]), 24'(radio_state));
      chk("ooi", 24'h1, 24'(out_of_idle_indicator));
      crc_valid_in = 1'b1;
      tick(3);
      chk("crc", 24'h1, 24'(crc_ok_indicator));
      crc_valid_in = 1'b0;
      radio_op_enable_in = 1'b0;
      tick(6);
      chk("idle", 24'(ST_IDLE), 24'(radio_state));
      chk("ind_off", 24'h0, 24'({crc_ok_indicator, out_of_idle_indicator}));
    end
    for (int k = 0; k < 2; k++) begin
      ctrl(k ? 8'h20 : 8'h10);
      chk("sleep", k ? 24'(ST_HIB) : 24'(ST_DOZE), 24'(radio_state));
      wake_request_in = 1'b1;
      tick(6);
      chk("woken", 24'(ST_IDLE), 24'(radio_state));
      wake_request_in = 1'b0;
      tick(2);
    end
    // Reset in mid-run must drop the control word as well
    ctrl(8'h81);
    radio_op_enable_in = 1'b1;
    tick(6);
    rst_b = 1'b0;
    tick(3);
    chk("off", 24'(ST_OFF), 24'(radio_state));
    rst_b = 1'b1;
    tick(6);
    chk("rst_idle", 24'(ST_IDLE), 24'(radio_state));
    chk("rst_ooi", 24'h0, 24'(out_of_idle_indicator));
    radio_op_enable_in = 1'b0;
  endtask : t_modes

  task automatic wrap_up;
    if (errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    {rst_b, wake_request_in, radio_op_enable_in, core_irq_event, crc_valid_in} = '0;
    {word_ready, oe_bad, oe_seen} = '0;
    read_word_in = 16'h0;
    errors = 0;
    n_tests = 0;
    tick(20);
    rst_b = 1'b1;
    tick(4);
    t_reset();
    t_frames();
    t_buffer();
    t_read();
    t_irq();
    t_modes();
    chk("quiet", 24'h0, 24'(oe_bad));
    wrap_up();
  end
  // Tests need well under 200 us; a hang is cut short here
  initial begin
    #1_000_000;
    errors++;
    wrap_up();
  end
endmodule : tb_top

// >>> hdl/modem_link.sv
// Modem serial slave, control pins, status pins and interrupt output
`timescale 1ns/10ps
`include "modem_link_defines.svh"
module modem_link
  import modem_link_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        serial_clock_in,
  input  wire logic        select_in_b,
  input  wire logic        mosi_in,
  output logic             miso_out,
  output logic             miso_oe,
  input  wire logic        wake_request_in,
  input  wire logic        radio_op_enable_in,
  output logic             modem_irq_b,
  output logic             crc_ok_indicator,
  output logic             out_of_idle_indicator,
  input  wire logic        core_irq_event,
  input  wire logic        crc_valid_in,
  input  wire logic [15:0] read_word_in,
  output logic             word_valid,
  input  wire logic        word_ready,
  output logic [23:0]      word_data,
  output logic [2:0]       radio_state
);

  // ****************************************
  // Link domain: shifter and framing
  // ****************************************
  logic                   spi_rst_b;
  logic [2:0]             bit_cnt_r, bit_cnt_nxt;
  logic [1:0]             byte_idx_r, byte_idx_nxt;
  logic [7:0]             shift_r, shift_nxt;
  logic [7:0]             hdr_r, hdr_nxt;
  logic [7:0]             hi_r, hi_nxt;
  logic [`WORD_W-1:0]     wr_word_r, wr_word_nxt;
  logic                   wr_tgl_r, rd_tgl_r;
  logic                   byte_done, hdr_done, word_done, stat_rd_hit;
  logic                   miso_r, miso_nxt, miso_oe_r;
  logic [7:0]             tx_byte;
  logic [15:0]            rd_sel;
  logic [2:0]             bit_pos;
  logic [4:0]             chk_bit_r, chk_bit_nxt;

  // Chip select high holds the link logic in reset: clock and MOSI ignored
  assign spi_rst_b   = rst_b & ~select_in_b;
  assign shift_nxt   = {shift_r[6:0], mosi_in};
  assign byte_done   = (bit_cnt_r == `BIT_LAST);
  assign bit_cnt_nxt = bit_cnt_r + 3'h1;
  assign hdr_done    = byte_done & (byte_idx_r == `BYTE_HDR);
  assign word_done   = byte_done & (byte_idx_r == `BYTE_LO) & ~hdr_r[`HDR_RD_BIT];
  assign stat_rd_hit = hdr_done & shift_nxt[`HDR_RD_BIT]
                     & (shift_nxt[`HDR_ADDR_MSB:0] == `ADDR_STAT);
  assign hdr_nxt     = hdr_done ? shift_nxt : hdr_r;
  assign hi_nxt      = (byte_done & (byte_idx_r == `BYTE_HI)) ? shift_nxt : hi_r;
  assign wr_word_nxt = word_done ? {hdr_r, hi_r, shift_nxt} : wr_word_r;
  assign chk_bit_nxt = (chk_bit_r == `CHK_WORD_END) ? `CHK_WORD_START : chk_bit_r + 5'h01;

  // Third burst completes the first word; a shorter frame delivers nothing
  always_comb begin
    byte_idx_nxt = byte_idx_r;
    if (byte_done) begin
      if (byte_idx_r == `BYTE_HI) begin
        byte_idx_nxt = `BYTE_LO;
      end else begin
        byte_idx_nxt = `BYTE_HI;
      end
    end
  end

  // Rising edge samples MOSI
  always_ff @(posedge serial_clock_in or negedge spi_rst_b) begin
    if (!spi_rst_b) begin
      bit_cnt_r  <= 3'h0;
      byte_idx_r <= `BYTE_HDR;
      shift_r    <= 8'h00;
      hdr_r      <= 8'h00;
      hi_r       <= 8'h00;
      chk_bit_r  <= 5'h00;
    end else begin
      bit_cnt_r  <= bit_cnt_nxt;
      byte_idx_r <= byte_idx_nxt;
      shift_r    <= shift_nxt;
      hdr_r      <= hdr_nxt;
      hi_r       <= hi_nxt;
      chk_bit_r  <= chk_bit_nxt;
    end
  end

  // Word and toggles survive the end of a frame; only chip reset clears them
  always_ff @(posedge serial_clock_in or negedge rst_b) begin
    if (!rst_b) begin
      wr_word_r <= '0;
      wr_tgl_r  <= 1'b0;
      rd_tgl_r  <= 1'b0;
    end else begin
      wr_word_r <= wr_word_nxt;
      wr_tgl_r  <= wr_tgl_r ^ word_done;
      rd_tgl_r  <= rd_tgl_r ^ stat_rd_hit;
    end
  end

  // ****************************************
  // Link domain: MISO
  // ****************************************
  logic [15:0] status_word;
  logic [15:0] rd_hold_r, stat_hold_r;

  // Read sources are held still by the system side while a frame runs
  assign rd_sel  = (hdr_r[`HDR_ADDR_MSB:0] == `ADDR_STAT) ? stat_hold_r : rd_hold_r;
  assign tx_byte = (byte_idx_r == `BYTE_HI) ? rd_sel[15:8] : rd_sel[7:0];
  assign bit_pos = `BIT_LAST - bit_cnt_r;
  // Header time and write frames carry nothing back
  assign miso_nxt = (byte_idx_r != `BYTE_HDR) & hdr_r[`HDR_RD_BIT]
                  & tx_byte[bit_pos];

  // Falling edge changes MISO; the slave never drives the clock
  always_ff @(negedge serial_clock_in or negedge spi_rst_b) begin
    if (!spi_rst_b) begin
      miso_r    <= 1'b0;
      miso_oe_r <= 1'b0;
    end else begin
      miso_r    <= miso_nxt;
      miso_oe_r <= 1'b1;
    end
  end

  assign miso_out = miso_r;
  assign miso_oe  = miso_oe_r;

  // ****************************************
  // System domain: synchronisers
  // ****************************************
  logic wr_s1_r, wr_s2_r, wr_s3_r;
  logic rd_s1_r, rd_s2_r, rd_s3_r;
  logic wake_s1_r, wake_s2_r;
  logic en_s1_r, en_s2_r;
  logic sel_s1_r, sel_s2_r;
  logic wr_evt, stat_rd_evt;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_s1_r   <= 1'b0;
      wr_s2_r   <= 1'b0;
      wr_s3_r   <= 1'b0;
      rd_s1_r   <= 1'b0;
      rd_s2_r   <= 1'b0;
      rd_s3_r   <= 1'b0;
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
      en_s1_r   <= 1'b0;
      en_s2_r   <= 1'b0;
      sel_s1_r  <= 1'b1;
      sel_s2_r  <= 1'b1;
    end else begin
      wr_s1_r   <= wr_tgl_r;
      wr_s2_r   <= wr_s1_r;
      wr_s3_r   <= wr_s2_r;
      rd_s1_r   <= rd_tgl_r;
      rd_s2_r   <= rd_s1_r;
      rd_s3_r   <= rd_s2_r;
      wake_s1_r <= wake_request_in;
      wake_s2_r <= wake_s1_r;
      en_s1_r   <= radio_op_enable_in;
      en_s2_r   <= en_s1_r;
      sel_s1_r  <= select_in_b;
      sel_s2_r  <= sel_s1_r;
    end
  end

  // Word register is stable for at least sixteen link clocks after a toggle
  assign wr_evt      = wr_s2_r ^ wr_s3_r;
  assign stat_rd_evt = rd_s2_r ^ rd_s3_r;

  // ****************************************
  // System domain: power state
  // ****************************************
  pwr_state_e   state_r, state_nxt;
  logic [15:0]  ctrl_r, ctrl_nxt;
  logic [1:0]   ctrl_op;
  logic         link_live, ctrl_wr, data_wr;
  logic [5:0]   wr_addr;

  assign ctrl_op   = ctrl_r[`CTRL_OP_MSB:`CTRL_OP_LSB];
  assign wr_addr   = wr_word_r[16+`HDR_ADDR_MSB:16];
  // Serial writes are dropped while the reference is stopped or parked; reads and status clears still work
  assign link_live = (state_r != ST_OFF) & (state_r != ST_DOZE) & (state_r != ST_HIB);
  assign ctrl_wr   = wr_evt & link_live & (wr_addr == `ADDR_CTRL);
  assign data_wr   = wr_evt & link_live & (wr_addr != `ADDR_CTRL);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        state_nxt = ST_IDLE;
      end
      ST_IDLE: begin
        if (ctrl_r[`CTRL_HIB]) begin
          state_nxt = ST_HIB;
        end else if (ctrl_r[`CTRL_DOZE]) begin
          state_nxt = ST_DOZE;
        end else if (en_s2_r && ctrl_op == `OP_RX) begin
          state_nxt = ST_RX;
        end else if (en_s2_r && ctrl_op == `OP_TX) begin
          state_nxt = ST_TX;
        end else if (en_s2_r && ctrl_op == `OP_CCA) begin
          state_nxt = ST_CCA;
        end
      end
      ST_DOZE, ST_HIB: begin
        if (wake_s2_r) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_RX, ST_TX, ST_CCA: begin
        if (!en_s2_r) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Sleep requests are one-shot: cleared as the state is entered
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (state_nxt == ST_HIB || state_nxt == ST_DOZE) begin
      ctrl_nxt[`CTRL_HIB]  = 1'b0;
      ctrl_nxt[`CTRL_DOZE] = 1'b0;
    end
    if (ctrl_wr) begin
      ctrl_nxt = wr_word_r[15:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_OFF;
      ctrl_r  <= `CTRL_RST;
    end else begin
      state_r <= state_nxt;
      ctrl_r  <= ctrl_nxt;
    end
  end

  // ****************************************
  // System domain: word path, interrupt, status
  // ****************************************
  logic [`WORD_W-1:0] pend_r, pend_nxt;
  logic               pend_v_r, pend_v_nxt, buf_ready, push;
  logic               ovf_r, ovf_nxt, ovf_set;
  logic               irq_pend_r, irq_pend_nxt;
  logic               irq_b_r, crc_r, idle_r;
  logic [2:0]         state_out_r;

  // Pending slot absorbs one word while the buffer is full
  assign push       = pend_v_r & buf_ready;
  assign ovf_set    = data_wr & pend_v_r & ~push;
  assign pend_v_nxt = (data_wr & ~ovf_set) | (pend_v_r & ~push);
  assign pend_nxt   = (data_wr & ~ovf_set) ? wr_word_r : pend_r;
  // Only bits the frozen status reported are cleared; an event beats a clear
  assign ovf_nxt      = ovf_set | (ovf_r & ~(stat_rd_evt & stat_hold_r[`STAT_OVF_BIT]));
  assign irq_pend_nxt = core_irq_event | ovf_set
                      | (irq_pend_r & ~(stat_rd_evt & stat_hold_r[`STAT_IRQ_BIT]));
  assign status_word  = {state_r, irq_pend_r, ovf_r, 11'h000};

  word_buffer2 #(.W(`WORD_W)) u_buf (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .in_valid  (pend_v_r),
    .in_ready  (buf_ready),
    .in_data   (pend_r),
    .out_valid (word_valid),
    .out_ready (word_ready),
    .out_data  (word_data)
  );

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pend_r     <= '0;
      pend_v_r   <= 1'b0;
      ovf_r      <= 1'b0;
      irq_pend_r <= 1'b0;
    end else begin
      pend_r     <= pend_nxt;
      pend_v_r   <= pend_v_nxt;
      ovf_r      <= ovf_nxt;
      irq_pend_r <= irq_pend_nxt;
    end
  end

  // Read word only reloads between frames so MISO never tears
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_hold_r   <= 16'h0000;
      stat_hold_r <= 16'h0000;
    end else if (sel_s2_r) begin
      rd_hold_r   <= read_word_in;
      stat_hold_r <= status_word;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_b_r     <= 1'b1;
      crc_r       <= 1'b0;
      idle_r      <= 1'b0;
      state_out_r <= 3'h0;
    end else begin
      irq_b_r     <= ~irq_pend_r;
      crc_r       <= ctrl_r[`CTRL_STREAM] & crc_valid_in;
      idle_r      <= ctrl_r[`CTRL_STREAM] & (state_r != ST_IDLE);
      state_out_r <= state_r;
    end
  end

  assign modem_irq_b           = irq_b_r;
  assign crc_ok_indicator      = crc_r;
  assign out_of_idle_indicator = idle_r;
  assign radio_state           = state_out_r;

  // ****************************************
  // Checks
  // ****************************************
  AST_CRC_IND: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ctrl_r[`CTRL_STREAM] && crc_valid_in) |=> crc_ok_indicator)
    else $error("crc indicator did not follow valid check");

  AST_IDLE_IND: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_r != ST_IDLE) |=> (out_of_idle_indicator == $past(ctrl_r[`CTRL_STREAM])))
    else $error("out of idle indicator wrong");

  AST_WAKE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ((state_r == ST_HIB || state_r == ST_DOZE) && wake_s2_r) |=> (state_r == ST_IDLE))
    else $error("wake did not return to idle");

  AST_ENABLE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_r == ST_RX || state_r == ST_TX || state_r == ST_CCA) |-> $past(en_s2_r))
    else $error("radio operation without enable");

  AST_IRQ: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (core_irq_event && !stat_rd_evt) |-> ##2 !modem_irq_b)
    else $error("interrupt event not raised");

  AST_SELECT: assert property (@(posedge serial_clock_in) disable iff (!rst_b)
    select_in_b |-> (!miso_oe && !miso_out))
    else $error("miso driven without select");

  AST_WORD: assert property (@(posedge serial_clock_in) disable iff (!spi_rst_b)
    word_done |-> (chk_bit_r == `CHK_WORD_END))
    else $error("word completed off a burst boundary");

  AST_OFF_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_r == ST_OFF) |=> (state_r == ST_IDLE))
    else $error("did not leave off state");

  AST_CTRL: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ctrl_wr && state_r == ST_IDLE) |=> (ctrl_r == $past(wr_word_r[15:0])))
    else $error("control write lost");

endmodule : modem_link

// >>> hdl/modem_link_defines.svh
// Constants for the modem serial link, control pins and status pins
`ifndef MODEM_LINK_DEFINES_SVH
`define MODEM_LINK_DEFINES_SVH

// ****************************************
// Header byte and addresses
// ****************************************
`define HDR_RD_BIT   7
`define HDR_ADDR_MSB 5
`define ADDR_CTRL    6'h01
`define ADDR_STAT    6'h02
`define STAT_IRQ_BIT 12
`define STAT_OVF_BIT 11

// ****************************************
// Control word fields
// ****************************************
`define CTRL_OP_MSB  1
`define CTRL_OP_LSB  0
`define CTRL_DOZE    4
`define CTRL_HIB     5
`define CTRL_STREAM  7
`define CTRL_RST     16'h0000
`define OP_RX        2'h1
`define OP_TX        2'h2
`define OP_CCA       2'h3

// ****************************************
// Burst framing
// ****************************************
`define BIT_LAST     3'h7
`define BYTE_HDR     2'h0
`define BYTE_HI      2'h1
`define BYTE_LO      2'h2
`define WORD_W       24
`define CHK_WORD_END   5'h17
`define CHK_WORD_START 5'h08

`endif

// >>> hdl/modem_link_pkg.sv
// Types shared by the modem link design
package modem_link_pkg;
  typedef enum logic [2:0] {ST_OFF, ST_IDLE, ST_DOZE, ST_HIB, ST_RX, ST_TX, ST_CCA} pwr_state_e;
endpackage : modem_link_pkg

// >>> hdl/word_buffer2.sv
// Two-entry word buffer with registered head slot
`timescale 1ns/10ps
module word_buffer2 #(
  parameter int W = 24
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] s0_r, s1_r, s0_nxt, s1_nxt, d0;
  logic         v0_r, v1_r, v0_nxt, v1_nxt;
  logic         push, pop, a0, a1;

  // Head always sits in slot 0 so the reader sees a flip-flop
  assign in_ready  = ~v1_r;
  assign out_valid = v0_r;
  assign out_data  = s0_r;
  assign push      = in_valid & ~v1_r;
  assign pop       = v0_r & out_ready;
  assign a0        = pop ? v1_r : v0_r;
  assign a1        = pop ? 1'b0 : v1_r;
  assign d0        = pop ? s1_r : s0_r;
  assign v0_nxt    = a0 | push;
  assign v1_nxt    = a1 | (push & a0);
  assign s0_nxt    = (push & ~a0) ? in_data : d0;
  assign s1_nxt    = (push & a0) ? in_data : s1_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      v0_r <= 1'b0;
      v1_r <= 1'b0;
      s0_r <= '0;
      s1_r <= '0;
    end else begin
      v0_r <= v0_nxt;
      v1_r <= v1_nxt;
      s0_r <= s0_nxt;
      s1_r <= s1_nxt;
    end
  end
endmodule : word_buffer2
